// >>> logic/atc_params.svh
// What this block does
// - Each channel's 8-bit pointer register gives the target register where transfer begins.
// - Enable bit 7 set: fetch once per sample period; clear: channel idle.
// - Swap bit 6 set: exchange bytes of every fully fetched word.
// - Never swap an unpaired first or last byte.
// - Swapped pair: higher-address byte to lower slot, lower-address byte next.
// - Swap clear: bytes go to consecutive slots in arrival order.
// - Skip bit 5 set: no pointer phase, only data read or write.
// - Alignment bit 4: zero pairs 0/1, 2/3; one pairs 1/2, 3/4.
// - Control bits 3:0 give bytes fetched per transfer.
// - Address register bit 7: one reads the target, zero writes it.
// - Address register bits 6:0 are sent as the target bus address.
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

`define ATC_ADR_T1_DEV    8'h28
`define ATC_ADR_T1_PTR    8'h29
`define ATC_ADR_T1_CTRL   8'h2A
`define ATC_ADR_T2_DEV    8'h2B
`define ATC_ADR_T2_PTR    8'h2C
`define ATC_ADR_T2_CTRL   8'h2D
`define ATC_ADR_SLOT_BASE 8'h60
`define ATC_ADR_T1_DOUT   8'h80
`define ATC_ADR_T2_DOUT   8'h81
`define ATC_SLOT_COUNT    8'h18
`define ATC_REG_RESET     8'h00

`define ATC_CTRL_EN       7
`define ATC_CTRL_SWAP     6
`define ATC_CTRL_SKIP     5
`define ATC_CTRL_ALIGN    4
`define ATC_DEV_DIR       7

`define ATC_SYS_CLK_NS    25
`define ATC_BIT_TIME_NS   2500
`define ATC_QTR_CYC       (((`ATC_BIT_TIME_NS / 4) + `ATC_SYS_CLK_NS - 1) / `ATC_SYS_CLK_NS)

`endif

// >>> logic/atc_pkg.sv
`default_nettype none
package atc_pkg;

  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} atc_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_PTR, ST_RESTART, ST_ADDR_RD, ST_READ, ST_WRITE, ST_STOP
  } atc_state_t;

endpackage
`default_nettype wire

// >>> logic/atc_byte_engine.sv
`timescale 1ns/100ps
`default_nettype none
module atc_byte_engine
  import atc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_qtick,
  input  wire logic       i_cmd_valid,
  input  wire atc_cmd_t   i_cmd,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_nack_last,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_done,
  output logic [7:0]      o_rx_byte,
  output logic            o_nack,
  output logic            o_scl_oe,
  output logic            o_sda_oe
);

  logic       busy_q;
  atc_cmd_t   cmd_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [8:0] rx_q;
  logic       done_q;
  logic       scl_oe_q;
  logic       sda_oe_q;

  wire is_byte = (cmd_q == CMD_WRITE) || (cmd_q == CMD_READ);
  // A target holding the clock low delays the high phase
  wire stall   = (ph_q == 2'd2) && !i_scl;
  wire step    = busy_q && i_qtick && !stall;
  wire last    = !is_byte || (bit_q == 4'd8);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      busy_q   <= 1'b0;
      cmd_q    <= CMD_START;
      ph_q     <= 2'd0;
      bit_q    <= 4'h0;
      sh_q     <= 9'h1FF;
      rx_q     <= 9'h000;
      done_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && i_cmd_valid)
      begin
        busy_q <= 1'b1;
        cmd_q  <= i_cmd;
        ph_q   <= 2'd0;
        bit_q  <= 4'h0;
        // Ninth bit: released for target ack, or our own ack/nack on reads
        sh_q   <= (i_cmd == CMD_READ) ? {8'hFF, i_nack_last} : {i_tx_byte, 1'b1};
      end
      else if (step)
      begin
        ph_q <= ph_q + 2'd1;
        case (ph_q)
          2'd0:
            sda_oe_q <= (cmd_q == CMD_START) ? 1'b0 :
                        (cmd_q == CMD_STOP)  ? 1'b1 : ~sh_q[8];
          2'd1:
            scl_oe_q <= 1'b0;
          2'd2:
          begin
            if (cmd_q == CMD_START)
              sda_oe_q <= 1'b1;
            else if (cmd_q == CMD_STOP)
              sda_oe_q <= 1'b0;
            else
              rx_q <= {rx_q[7:0], i_sda};
          end
          default:
          begin
            if (cmd_q != CMD_STOP)
              scl_oe_q <= 1'b1;
            sh_q  <= {sh_q[7:0], 1'b1};
            bit_q <= bit_q + 4'h1;
            if (last)
            begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign o_done    = done_q;
  assign o_rx_byte = rx_q[8:1];
  assign o_nack    = rx_q[0];
  assign o_scl_oe  = scl_oe_q;
  assign o_sda_oe  = sda_oe_q;

endmodule // atc_byte_engine
`default_nettype wire

// >>> logic/atc_channels.sv
`timescale 1ns/100ps
`default_nettype none
`include "atc_params.svh"
module atc_channels
  import atc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sample_tick,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  output logic            o_busy,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe
);

  function automatic logic pair_start(input logic [7:0] a, input logic align);
    pair_start = (a[0] == align);
  endfunction

  function automatic logic [5:0] slot_dest(
    input logic [4:0] base,
    input logic [3:0] k,
    input logic [3:0] n,
    input logic [7:0] ptr,
    input logic       swap,
    input logic       align
  );
    logic [7:0] a;
    logic       st;
    logic       more;
    a    = ptr + {4'h0, k};
    st   = pair_start(a, align);
    more = (({1'b0, k} + 5'h01) < {1'b0, n});
    if (swap && st && more)
      slot_dest = {1'b0, base} + {2'b00, k} + 6'h01;
    else if (swap && !st && (k != 4'h0))
      slot_dest = {1'b0, base} + {2'b00, k} - 6'h01;
    else
      slot_dest = {1'b0, base} + {2'b00, k};
  endfunction

  logic [7:0] dev_q  [2];
  logic [7:0] ptr_q  [2];
  logic [7:0] ctrl_q [2];
  logic [7:0] dout_q [2];
  logic [7:0] slot_q [`ATC_SLOT_COUNT];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       busy_q;
  logic       low_q;
  logic       scl_m_q;
  logic       scl_s_q;
  logic       sda_m_q;
  logic       sda_s_q;
  logic [4:0] div_q;
  logic       qtick_q;
  atc_state_t st_q;
  atc_state_t st_d;
  logic       cur_q;
  logic       cur_d;
  logic [3:0] k_q;
  logic [3:0] k_d;
  logic [1:0] pend_q;
  logic       wait_q;
  logic       eng_done;
  logic [7:0] eng_rx;
  logic       eng_nack;

  wire wr_t1_dev  = i_reg_wr && (i_reg_addr == `ATC_ADR_T1_DEV);
  wire wr_t1_ptr  = i_reg_wr && (i_reg_addr == `ATC_ADR_T1_PTR);
  wire wr_t1_ctrl = i_reg_wr && (i_reg_addr == `ATC_ADR_T1_CTRL);
  wire wr_t2_dev  = i_reg_wr && (i_reg_addr == `ATC_ADR_T2_DEV);
  wire wr_t2_ptr  = i_reg_wr && (i_reg_addr == `ATC_ADR_T2_PTR);
  wire wr_t2_ctrl = i_reg_wr && (i_reg_addr == `ATC_ADR_T2_CTRL);
  wire wr_t1_dout = i_reg_wr && (i_reg_addr == `ATC_ADR_T1_DOUT);
  wire wr_t2_dout = i_reg_wr && (i_reg_addr == `ATC_ADR_T2_DOUT);

  wire [7:0] slot_off = i_reg_addr - `ATC_ADR_SLOT_BASE;
  wire       slot_rd  = (i_reg_addr >= `ATC_ADR_SLOT_BASE) && (slot_off < `ATC_SLOT_COUNT);

  wire [1:0] en         = {ctrl_q[1][`ATC_CTRL_EN], ctrl_q[0][`ATC_CTRL_EN]};
  wire [7:0] cur_dev    = dev_q[cur_q];
  wire [7:0] cur_ptr    = ptr_q[cur_q];
  wire [7:0] cur_ctrl   = ctrl_q[cur_q];
  wire [7:0] cur_dout   = dout_q[cur_q];
  wire [6:0] cur_addr7  = cur_dev[6:0];
  wire       cur_rnw    = cur_dev[`ATC_DEV_DIR];
  wire       cur_swap   = cur_ctrl[`ATC_CTRL_SWAP];
  wire       cur_skip   = cur_ctrl[`ATC_CTRL_SKIP];
  wire       cur_align  = cur_ctrl[`ATC_CTRL_ALIGN];
  wire [3:0] cur_len    = cur_ctrl[3:0];
  wire       len_zero   = (cur_len == 4'h0);
  wire       last_byte  = (({1'b0, k_q} + 5'h01) == {1'b0, cur_len});

  wire [4:0] base_t2    = en[0] ? {1'b0, ctrl_q[0][3:0]} : 5'h00;
  wire [4:0] cur_base   = cur_q ? base_t2 : 5'h00;

  wire [5:0] dest       = slot_dest(cur_base, k_q, cur_len, cur_ptr, cur_swap, cur_align);
  wire [5:0] dest_plain = {1'b0, cur_base} + {2'b00, k_q};
  wire [7:0] cur_raddr  = cur_ptr + {4'h0, k_q};
  wire       slot_we    = (st_q == ST_READ) && eng_done;

  wire [7:0] eng_tx =
    (st_q == ST_PTR)     ? cur_ptr :
    (st_q == ST_WRITE)   ? cur_dout :
    (st_q == ST_ADDR_RD) ? {cur_addr7, 1'b1} :
    {cur_addr7, cur_skip & cur_rnw};
  wire atc_cmd_t eng_cmd =
    (st_q == ST_STOP) ? CMD_STOP :
    (st_q == ST_READ) ? CMD_READ :
    ((st_q == ST_START) || (st_q == ST_RESTART)) ? CMD_START : CMD_WRITE;
  wire eng_valid = (st_q != ST_IDLE) && !wait_q;

  wire [1:0] pend_clr = (st_q == ST_STOP && eng_done) ? (cur_q ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] pend_d   = ((pend_q & ~pend_clr) | (i_sample_tick ? en : 2'b00)) & en;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        dev_q[c]  <= `ATC_REG_RESET;
        ptr_q[c]  <= `ATC_REG_RESET;
        ctrl_q[c] <= `ATC_REG_RESET;
        dout_q[c] <= `ATC_REG_RESET;
      end
    end
    else
    begin
      if (wr_t1_dev)  dev_q[0]  <= i_reg_wdata;
      if (wr_t1_ptr)  ptr_q[0]  <= i_reg_wdata;
      if (wr_t1_ctrl) ctrl_q[0] <= i_reg_wdata;
      if (wr_t2_dev)  dev_q[1]  <= i_reg_wdata;
      if (wr_t2_ptr)  ptr_q[1]  <= i_reg_wdata;
      if (wr_t2_ctrl) ctrl_q[1] <= i_reg_wdata;
      if (wr_t1_dout) dout_q[0] <= i_reg_wdata;
      if (wr_t2_dout) dout_q[1] <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      for (int s = 0; s < `ATC_SLOT_COUNT; s++)
        slot_q[s] <= 8'h00;
    else if (slot_we && (dest < 6'(`ATC_SLOT_COUNT)))
      slot_q[dest[4:0]] <= eng_rx;
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (i_reg_addr == `ATC_ADR_T1_DEV)       rdata_d = dev_q[0];
    else if (i_reg_addr == `ATC_ADR_T1_PTR)  rdata_d = ptr_q[0];
    else if (i_reg_addr == `ATC_ADR_T1_CTRL) rdata_d = ctrl_q[0];
    else if (i_reg_addr == `ATC_ADR_T2_DEV)  rdata_d = dev_q[1];
    else if (i_reg_addr == `ATC_ADR_T2_PTR)  rdata_d = ptr_q[1];
    else if (i_reg_addr == `ATC_ADR_T2_CTRL) rdata_d = ctrl_q[1];
    else if (i_reg_addr == `ATC_ADR_T1_DOUT) rdata_d = dout_q[0];
    else if (i_reg_addr == `ATC_ADR_T2_DOUT) rdata_d = dout_q[1];
    else if (slot_rd)                        rdata_d = slot_q[slot_off[4:0]];
  end

  // Bit timing runs at a fixed quarter-bit rate; no run-time clock selection
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || (div_q == 5'(`ATC_QTR_CYC - 1)))
      div_q <= 5'h00;
    else
      div_q <= div_q + 5'h01;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      qtick_q <= 1'b0;
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      rdata_q <= 8'h00;
      busy_q  <= 1'b0;
      low_q   <= 1'b0;
    end
    else
    begin
      qtick_q <= (div_q == 5'(`ATC_QTR_CYC - 1));
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= i_sda;
      sda_s_q <= sda_m_q;
      rdata_q <= rdata_d;
      busy_q  <= (st_d != ST_IDLE);
      low_q   <= 1'b0;
    end
  end

  always_comb
  begin
    st_d  = st_q;
    cur_d = cur_q;
    k_d   = k_q;
    case (st_q)
      ST_IDLE:
        // ascending service
        // Pending lags a disable by one cycle, so gate with enable too
        if (pend_q[0] && en[0])
        begin
          cur_d = 1'b0;
          k_d   = 4'h0;
          st_d  = ST_START;
        end
        else if (pend_q[1] && en[1])
        begin
          cur_d = 1'b1;
          k_d   = 4'h0;
          st_d  = ST_START;
        end
      ST_START:
        if (eng_done) st_d = ST_ADDR;
      ST_ADDR:
        if (eng_done)
        begin
          if (eng_nack)       st_d = ST_STOP;
          else if (!cur_skip) st_d = ST_PTR;
          else if (!cur_rnw)  st_d = ST_WRITE;
          else if (len_zero)  st_d = ST_STOP;
          else                st_d = ST_READ;
        end
      ST_PTR:
        if (eng_done)
        begin
          if (eng_nack)     st_d = ST_STOP;
          else if (cur_rnw) st_d = ST_RESTART;
          else              st_d = ST_WRITE;
        end
      ST_RESTART:
        if (eng_done) st_d = ST_ADDR_RD;
      ST_ADDR_RD:
        if (eng_done) st_d = (eng_nack || len_zero) ? ST_STOP : ST_READ;
      ST_READ:
        if (eng_done)
        begin
          k_d = k_q + 4'h1;
          if (last_byte) st_d = ST_STOP;
        end
      ST_WRITE:
        if (eng_done) st_d = ST_STOP;
      ST_STOP:
        if (eng_done) st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_q   <= ST_IDLE;
      cur_q  <= 1'b0;
      k_q    <= 4'h0;
      pend_q <= 2'b00;
      wait_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      k_q    <= k_d;
      pend_q <= pend_d;
      wait_q <= eng_done ? 1'b0 : (eng_valid ? 1'b1 : wait_q);
    end
  end

  atc_byte_engine u_engine (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_qtick     (qtick_q),
    .i_cmd_valid (eng_valid),
    .i_cmd       (eng_cmd),
    .i_tx_byte   (eng_tx),
    .i_nack_last (last_byte),
    .i_scl       (scl_s_q),
    .i_sda       (sda_s_q),
    .o_done      (eng_done),
    .o_rx_byte   (eng_rx),
    .o_nack      (eng_nack),
    .o_scl_oe    (o_scl_oe),
    .o_sda_oe    (o_sda_oe)
  );

  assign o_reg_rdata = rdata_q;
  assign o_busy      = busy_q;
  assign o_scl       = low_q;
  assign o_sda       = low_q;

  a_ptr_sent: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_PTR && eng_valid) |-> (eng_tx == ptr_q[cur_q]) && (eng_cmd == CMD_WRITE))
    else $error("pointer phase sends wrong byte");

  a_idle_when_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_IDLE && en == 2'b00) |=> (st_q == ST_IDLE) [*2])
    else $error("disabled channels started a transfer");

  a_swap_pair: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && cur_swap && pair_start(cur_raddr, cur_align) && !last_byte)
      |-> (dest == dest_plain + 6'h01))
    else $error("swapped pair start not placed in upper slot");

  a_unpaired_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && k_q == 4'h0 && !pair_start(cur_raddr, cur_align)) |-> (dest == dest_plain))
    else $error("unpaired first byte was moved");

  a_plain_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && !cur_swap) |-> (dest == dest_plain))
    else $error("unswapped byte out of order");

  a_align_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && cur_swap && k_q != 4'h0 && (cur_raddr[0] != cur_align))
      |-> (dest == dest_plain - 6'h01))
    else $error("pair end not placed below its partner");

  a_skip_ptr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_ADDR && eng_done && !eng_nack) |=> ((st_q == ST_PTR) == !$past(cur_skip)))
    else $error("pointer phase does not follow the skip bit");

  a_read_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && last_byte) |=> (st_q == ST_STOP) && (k_q == cur_len))
    else $error("read phase byte count mismatch");

  a_addr_dir: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_WRITE) |-> !cur_rnw)
    else $error("write phase on a read channel");

  a_addr_byte: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_ADDR_RD && eng_valid) |-> (eng_tx[7:1] == cur_dev[6:0]) && eng_tx[0])
    else $error("target address byte wrong");

  a_slot_base: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (slot_we && cur_q && k_q == 4'h0 && !cur_swap)
      |-> (dest == (en[0] ? {2'b00, ctrl_q[0][3:0]} : 6'h00)))
    else $error("second channel base slot wrong");

  a_chan_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q == ST_IDLE && pend_q[0] && en[0]) |=> (st_q == ST_START) && !cur_q)
    else $error("first channel not serviced first");

endmodule // atc_channels
`default_nettype wire

// >>> tb/atc_tgt_model.sv
`timescale 1ns/100ps
`default_nettype none
module atc_tgt_model #(
  parameter logic [6:0] ADDR = 7'h1D
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_slow,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] log_q [$];
  logic [7:0] sh;
  logic [7:0] cur;
  logic [7:0] ptr = 8'h00;
  logic       rd = 1'b0;
  logic       hit = 1'b0;
  logic       mack = 1'b1;
  int         bitn = 0;
  int         nb = 0;
  time        t_go;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ {ADDR, 1'b1};
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Start or repeated start restarts the byte count
  always @(negedge i_sda)
    if (i_scl)
    begin
      bitn = 0;
      nb = 0;
      rd = 1'b0;
    end
  always @(posedge i_sda)
    if (i_scl)
      hit = 1'b0;
  always @(posedge i_scl)
  begin
    if (bitn < 8)
      sh = {sh[6:0], i_sda};
    else
      mack = i_sda;
    bitn++;
  end
  // Bytes from the master are logged and acknowledged only when addressed
  always @(negedge i_scl)
  begin
    if (bitn == 8 && (nb == 0 || !rd))
    begin
      if (nb == 0)
      begin
        hit = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      else if (nb == 1 && hit)
        ptr = sh;
      else if (hit)
      begin
        mem[ptr] = sh;
        ptr++;
      end
      if (hit && log_q.size() == 0)
        t_go = $time;
      if (hit)
        log_q.push_back(sh);
      o_sda_oe = hit;
      nb++;
    end
    else if (bitn == 8)
      o_sda_oe = 1'b0;
    else if (bitn == 9)
    begin
      bitn = 0;
      o_sda_oe = 1'b0;
      // A master NACK ends the served stream, so the pointer stays exact
      if (rd && hit && !mack)
      begin
        cur = mem[ptr];
        ptr++;
        o_sda_oe = ~cur[7];
      end
    end
    else if (rd && hit && nb > 0)
      o_sda_oe = ~cur[7 - bitn];
    // Slow answer stretches the clock at byte boundaries
    if (i_slow && bitn == 0 && nb > 0)
    begin
      o_scl_oe = 1'b1;
      #2500;
      o_scl_oe = 1'b0;
    end
  end
endmodule // atc_tgt_model
`default_nettype wire

// >>> tb/aux_i2c_target_channels_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module aux_i2c_target_channels_tb_top;
  import atc_pkg::*;
  typedef struct packed {
    logic [7:0] d1, p1, c1, d2, p2, c2;
    logic       slow;
  } atc_row_t;
  localparam atc_row_t ROWS [7] = '{
    '{8'h9D, 8'h01, 8'hC4, 8'hAE, 8'h00, 8'h00, 1'b0},
    '{8'h9D, 8'h10, 8'h83, 8'hAE, 8'h05, 8'hD3, 1'b1},
    '{8'h9D, 8'h07, 8'hC1, 8'hAE, 8'h02, 8'hD5, 1'b0},
    '{8'h9D, 8'h00, 8'h8F, 8'hAE, 8'h03, 8'hCA, 1'b0},
    '{8'h9D, 8'h06, 8'hE2, 8'hAE, 8'h01, 8'hA3, 1'b1},
    '{8'h1D, 8'h09, 8'h81, 8'hAE, 8'h00, 8'h00, 1'b0},
    '{8'h1D, 8'h04, 8'hA0, 8'hAE, 8'h0E, 8'h92, 1'b0}};
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       tick = 1'b0;
  logic       reg_wr = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       busy, scl_oe, sda_oe, scl_o, sda_o;
  logic       t1_scl, t1_sda, t2_scl, t2_sda;
  wire logic  scl_w = ~((scl_oe === 1'b1) | t1_scl | t2_scl);
  wire logic  sda_w = ~((sda_oe === 1'b1) | t1_sda | t2_sda);
  logic [7:0] exp_slot [24] = '{default: 8'h00};
  logic [7:0] eq [2][$];
  int         errors = 0;
  int         tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  atc_channels i_dut (
    .i_sys_clk     (sys_clk),
    .i_rst_n       (rst_n),
    .i_sample_tick (tick),
    .i_reg_addr    (reg_addr),
    .i_reg_wr      (reg_wr),
    .i_reg_wdata   (reg_wdata),
    .o_reg_rdata   (rdata),
    .o_busy        (busy),
    .i_scl         (scl_w),
    .o_scl         (scl_o),
    .o_scl_oe      (scl_oe),
    .i_sda         (sda_w),
    .o_sda         (sda_o),
    .o_sda_oe      (sda_oe)
  );
  atc_tgt_model #(.ADDR(7'h1D)) i_t1 (.i_scl(scl_w), .i_sda(sda_w), .i_slow(slow),
    .o_scl_oe(t1_scl), .o_sda_oe(t1_sda));
  atc_tgt_model #(.ADDR(7'h2E)) i_t2 (.i_scl(scl_w), .i_sda(sda_w), .i_slow(slow),
    .o_scl_oe(t2_scl), .o_sda_oe(t2_sda));

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    @(posedge sys_clk);
    #2;
    d = rdata;
  endtask

  task automatic pulse_tick();
    @(posedge sys_clk);
    #2;
    tick = 1'b1;
    @(posedge sys_clk);
    #2;
    tick = 1'b0;
  endtask

  // Skip mode reads from wherever the target pointer was left,
  // but pairing still follows the pointer register
  task automatic predict(input bit ch, input logic [7:0] d, p, c, inout int base);
    logic [7:0] pe;
    logic [7:0] ad;
    logic [7:0] pa;
    int         s;
    eq[ch].delete();
    if (!c[7])
      return;
    pe = c[5] ? (ch ? i_t2.ptr : i_t1.ptr) : p;
    if (!(c[5] && d[7]))
      eq[ch].push_back({d[6:0], 1'b0});
    if (!c[5])
      eq[ch].push_back(p);
    eq[ch].push_back(d[7] ? {d[6:0], 1'b1} : (ch ? 8'hA5 : 8'h5A));
    for (int k = 0; d[7] && k < c[3:0]; k++)
    begin
      ad = pe + k[7:0];
      pa = p + k[7:0];
      s = k;
      if (c[6] && pa[0] == c[4] && k + 1 < c[3:0])
        s = k + 1;
      else if (c[6] && pa[0] != c[4] && k > 0)
        s = k - 1;
      if (base + s < 24)
        exp_slot[base + s] = ch ? i_t2.mem[ad] : i_t1.mem[ad];
    end
    base += c[3:0];
  endtask

  task automatic cmp_log(input logic [7:0] got [$], input int ch);
    chk(8'(got.size()), 8'(eq[ch].size()));
    for (int i = 0; i < eq[ch].size(); i++)
      chk(got[i], eq[ch][i]);
  endtask

  task automatic run_row(input atc_row_t r);
    logic [7:0] cfg [6];
    int         base;
    int         idle;
    cfg = '{r.d1, r.p1, r.c1, r.d2, r.p2, r.c2};
    for (int i = 0; i < 6; i++)
      wr(8'h28 + i[7:0], cfg[i]);
    slow = r.slow;
    base = 0;
    predict(1'b0, r.d1, r.p1, r.c1, base);
    predict(1'b1, r.d2, r.p2, r.c2, base);
    i_t1.log_q.delete();
    i_t2.log_q.delete();
    pulse_tick();
    idle = 0;
    for (int n = 0; n < 60000 && idle < 400; n++)
    begin
      @(posedge sys_clk);
      #2;
      idle = (busy === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 400)
    begin
      errors++;
      final_report();
    end
    cmp_log(i_t1.log_q, 0);
    cmp_log(i_t2.log_q, 1);
    if (r.c1[7] && r.c2[7])
      chk(8'(i_t1.t_go < i_t2.t_go), 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'h28 + i[7:0], v);
      chk(v, cfg[i]);
    end
    for (int i = 0; i < 24; i++)
    begin
      rd(8'h60 + i[7:0], v);
      chk(v, exp_slot[i]);
    end
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    wr(8'h80, 8'h5A);
    wr(8'h81, 8'hA5);
    for (int i = 0; i < 7; i++)
      run_row(ROWS[i]);
    // Reset lands early in a long read, during its first address byte
    wr(8'h28, 8'h9D);
    wr(8'h2A, 8'h8F);
    pulse_tick();
    repeat (500) @(posedge sys_clk);
    #2;
    rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    chk({3'h0, scl_o, sda_o, busy, scl_oe, sda_oe}, 8'h00);
    wr(8'h61, 8'hFF);
    wr(8'h50, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'h28 + i[7:0], v);
      chk(v, 8'h00);
    end
    rd(8'h61, v);
    chk(v, 8'h00);
    rd(8'h50, v);
    chk(v, 8'h00);
    final_report();
  end
endmodule // aux_i2c_target_channels_tb_top
`default_nettype wire
